// file: hw/xadl_core.sv
// module: execution of direction-load, literal-xor and file-xor opcodes
`timescale 1ns/100ps
`default_nettype none

module xadl_core import xadl_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [13:0] instr,
  output logic [1:0] phase,
  output logic [7:0] accum,
  output logic zero,
  output logic [7:0] dir5,
  output logic [7:0] dir6,
  output logic [7:0] dir7,
  output logic done
);

  // decode one instruction word
  function automatic xadl_dec_type decode(input logic [13:0] w);
    xadl_dec_type d;
    d.is_dir = ((w & XADL_DIR_MASK) == XADL_DIR_CODE)
      && (w[XADL_SEL_MSB:0] >= XADL_DIR_LO) && (w[XADL_SEL_MSB:0] <= XADL_DIR_HI);
    d.is_xlit = (w & XADL_XLIT_MASK) == XADL_XLIT_CODE;
    d.is_xf = (w & XADL_XF_MASK) == XADL_XF_CODE;
    d.dest_file = w[XADL_D_BIT];
    d.faddr = w[XADL_F_MSB:0];
    d.lit = w[XADL_K_MSB:0];
    return d;
  endfunction : decode

  // file register array; addresses 5..7 are the direction registers
  logic [7:0] file_mem [XADL_NFILE];
  logic file_we;
  logic [7:0] file_rd;
  xadl_state_type s;
  xadl_state_type next_s;

  // file read, direction registers mapped in
  always_comb begin
    case (s.dec.faddr)
      XADL_DIR_BASE: file_rd = s.dir5;
      XADL_DIR_BASE + 7'h01: file_rd = s.dir6;
      XADL_DIR_BASE + 7'h02: file_rd = s.dir7;
      default: file_rd = file_mem[s.dec.faddr];
    endcase
  end

  assign file_we = (s.phase == XADL_Q4) && s.dec.is_xf && s.dec.dest_file;

  // next-state logic over the four phases
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.phase)
      XADL_Q1: begin
        next_s.dec = decode(instr);
        next_s.phase = XADL_Q2;
      end
      XADL_Q2: begin
        next_s.opnd = s.dec.is_xlit ? s.dec.lit : file_rd;
        next_s.phase = XADL_Q3;
      end
      XADL_Q3: begin
        next_s.result = s.accum ^ s.opnd;
        next_s.phase = XADL_Q4;
      end
      XADL_Q4: begin
        next_s.phase = XADL_Q1;
        next_s.done = 1'b1;
        if (s.dec.is_xlit) begin
          next_s.accum = s.result;
          next_s.zero = (s.result == 8'h00);
        end else if (s.dec.is_xf) begin
          next_s.zero = (s.result == 8'h00);
          if (!s.dec.dest_file) begin
            next_s.accum = s.result;
          end else begin
            case (s.dec.faddr)
              XADL_DIR_BASE: next_s.dir5 = s.result;
              XADL_DIR_BASE + 7'h01: next_s.dir6 = s.result;
              XADL_DIR_BASE + 7'h02: next_s.dir7 = s.result;
              default: ;
            endcase
          end
        end else if (s.dec.is_dir) begin
          case (s.dec.faddr[XADL_SEL_MSB:0])
            XADL_DIR_LO: next_s.dir5 = s.accum;
            XADL_DIR_LO + 3'h1: next_s.dir6 = s.accum;
            XADL_DIR_HI: next_s.dir7 = s.accum;
            default: ;
          endcase
        end
      end
      default: next_s.phase = XADL_Q1;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.phase <= XADL_Q1;
      s.dir5 <= XADL_DIR_RST;
      s.dir6 <= XADL_DIR_RST;
      s.dir7 <= XADL_DIR_RST;
    end else begin
      s <= next_s;
    end
  end

  // ordinary file write-back, no reset on the data array
  always_ff @(posedge clk_sys) begin
    if (file_we) begin
      file_mem[s.dec.faddr] <= s.result;
    end
  end

  assign phase = s.phase;
  assign accum = s.accum;
  assign zero = s.zero;
  assign dir5 = s.dir5;
  assign dir6 = s.dir6;
  assign dir7 = s.dir7;
  assign done = s.done;

  // literal-xor: four phases end in accumulator = old ^ literal
  sequence xlit_start_s;
    s.phase == XADL_Q1 && (instr & XADL_XLIT_MASK) == XADL_XLIT_CODE;
  endsequence

  property xlit_result_p;
    logic [7:0] a;
    logic [7:0] k;
    @(posedge clk_sys) disable iff (!rstn)
      (xlit_start_s, a = s.accum, k = instr[XADL_K_MSB:0]) |-> ##4 (accum == (a ^ k))
        && (zero == ((a ^ k) == 8'h00));
  endproperty
  literal_xor_a: assert property (xlit_result_p) else $error("literal xor wrong");

  property xlit_dir_keep_p;
    @(posedge clk_sys) disable iff (!rstn)
      xlit_start_s |-> ##4 ($stable(dir5) && $stable(dir6) && $stable(dir7));
  endproperty
  xlit_only_accum_a: assert property (xlit_dir_keep_p) else $error("literal xor leaked");

  // phase walk that follows every decode phase
  sequence phase_walk_s;
    s.phase == XADL_Q2 ##1 s.phase == XADL_Q3 ##1 s.phase == XADL_Q4 ##1 s.phase == XADL_Q1;
  endsequence

  phase_order_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    s.phase == XADL_Q1 |=> phase_walk_s) else $error("phase order broken");

  // direction-load: accumulator lands in the chosen register, flags and accumulator kept
  sequence dir_start_s;
    s.phase == XADL_Q1 && (instr & XADL_DIR_MASK) == XADL_DIR_CODE
      && instr[XADL_SEL_MSB:0] >= XADL_DIR_LO;
  endsequence

  property dir_load_p;
    logic [7:0] a;
    logic [2:0] f;
    @(posedge clk_sys) disable iff (!rstn)
      (dir_start_s, a = s.accum, f = instr[XADL_SEL_MSB:0])
        |-> ##4 ((f == XADL_DIR_LO ? dir5 : (f == XADL_DIR_HI ? dir7 : dir6)) == a)
        && $stable(zero) && $stable(accum);
  endproperty
  dir_load_a: assert property (dir_load_p) else $error("direction load wrong");

  dir_bad_nop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s.phase == XADL_Q1 && (instr & XADL_DIR_MASK) == XADL_DIR_CODE
    && instr[XADL_SEL_MSB:0] < XADL_DIR_LO)
    |-> ##4 ($stable(dir5) && $stable(dir6) && $stable(dir7) && $stable(accum)
    && $stable(zero))) else $error("bad operand not a no-op");

  property xf_to_accum_p;
    logic [7:0] r;
    @(posedge clk_sys) disable iff (!rstn)
      (s.phase == XADL_Q3 && s.dec.is_xf && !s.dec.dest_file, r = s.accum ^ s.opnd)
        |-> ##2 (accum == r);
  endproperty
  xf_accum_dest_a: assert property (xf_to_accum_p) else $error("file xor to accum");

  xf_file_dest_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s.phase == XADL_Q4 && s.dec.is_xf && s.dec.dest_file) |=> $stable(accum)
    && zero == (s.result == 8'h00)) else $error("file xor to file");

  xf_dir_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s.phase == XADL_Q4 && s.dec.is_xf && s.dec.dest_file && s.dec.faddr == XADL_DIR_BASE)
    |=> dir5 == $past(s.result)) else $error("direction file write");

  xf_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s.phase == XADL_Q2 && s.dec.is_xf) |=> s.opnd == $past(file_rd))
    else $error("file operand read");

  // file-xor zero flag follows the operand read in the second phase
  property xf_zero_p;
    logic [7:0] r;
    @(posedge clk_sys) disable iff (!rstn)
      (s.phase == XADL_Q2 && s.dec.is_xf, r = s.accum ^ file_rd)
        |-> ##3 (zero == (r == 8'h00));
  endproperty
  xf_zero_flag_a: assert property (xf_zero_p) else $error("file xor zero flag");

  // accumulator destination leaves every direction register untouched
  xf_file_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s.phase == XADL_Q4 && s.dec.is_xf && !s.dec.dest_file)
    |=> $stable(dir5) && $stable(dir6) && $stable(dir7)) else $error("file changed");

  // file destination lands in the array
  xf_mem_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s.phase == XADL_Q4 && s.dec.is_xf && s.dec.dest_file)
    |=> file_mem[$past(s.dec.faddr)] == $past(s.result))
    else $error("file array write");

  // highest direction register written as a file
  xf_dir7_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s.phase == XADL_Q4 && s.dec.is_xf && s.dec.dest_file && s.dec.faddr == XADL_DIR_BASE + 7'h02)
    |=> dir7 == $past(s.result)) else $error("direction file write high");

  // retire pulse lasts one cycle after the fourth phase
  done_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    s.phase == XADL_Q4 |=> done ##1 !done) else $error("retire pulse wrong");

endmodule : xadl_core
`default_nettype wire

// file: hw/xadl_pkg.sv
// package: opcodes, phases and state layout for the xor and direction-load unit
package xadl_pkg;
  localparam int XADL_OP_W = 14;
  localparam logic [13:0] XADL_DIR_MASK = 14'h3FF8;
  localparam logic [13:0] XADL_DIR_CODE = 14'h0060;
  localparam logic [13:0] XADL_XLIT_MASK = 14'h3F00;
  localparam logic [13:0] XADL_XLIT_CODE = 14'h3A00;
  localparam logic [13:0] XADL_XF_MASK = 14'h3F00;
  localparam logic [13:0] XADL_XF_CODE = 14'h0600;
  localparam int XADL_D_BIT = 7;
  localparam int XADL_SEL_MSB = 2; // top bit of the direction-load operand
  localparam int XADL_F_MSB = 6; // top bit of the file address field
  localparam int XADL_K_MSB = 7; // top bit of the literal field
  localparam logic [2:0] XADL_DIR_LO = 3'h5;
  localparam logic [2:0] XADL_DIR_HI = 3'h7;
  localparam logic [6:0] XADL_DIR_BASE = 7'h05;
  localparam int XADL_NFILE = 128;
  localparam logic [7:0] XADL_DIR_RST = 8'hFF;

  typedef enum logic [1:0] {XADL_Q1, XADL_Q2, XADL_Q3, XADL_Q4} xadl_phase_type;

  typedef struct packed {
    logic is_dir;
    logic is_xlit;
    logic is_xf;
    logic dest_file;
    logic [6:0] faddr;
    logic [7:0] lit;
  } xadl_dec_type;

  typedef struct packed {
    xadl_phase_type phase;
    xadl_dec_type dec;
    logic [7:0] opnd;
    logic [7:0] result;
    logic [7:0] accum;
    logic zero;
    logic [7:0] dir5;
    logic [7:0] dir6;
    logic [7:0] dir7;
    logic done;
  } xadl_state_type;
endpackage : xadl_pkg

// file: testbench/xor_and_direction_load_ops_test.sv
// testbench: directed scenarios for the xor and direction-load unit
`timescale 1ns/100ps
`default_nettype none

module xor_and_direction_load_ops_test;
  import xadl_pkg::*;
  logic clk_sys, rstn;
  logic [13:0] instr;
  logic [1:0] phase;
  logic [7:0] accum, dir5, dir6, dir7;
  logic zero, done;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  xadl_core xadl_core_inst (.clk_sys(clk_sys), .rstn(rstn), .instr(instr), .phase(phase),
    .accum(accum), .zero(zero), .dir5(dir5), .dir6(dir6), .dir7(dir7), .done(done));

  // 100 ns clock
  always #50 clk_sys = ~clk_sys;

  // hang guard, far above the 17 instructions issued
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 2000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one instruction: taken at the q1 edge, retired three edges later
  task automatic exec(input logic [13:0] w);
    instr = w;
    for (int i = 1; i <= 4; i++) begin
      @(posedge clk_sys);
      #10;
      check({6'h00, phase}, 8'(i % 4));
      check({7'h00, done}, {7'h00, i == 4});
    end
  endtask : exec

  // compare every visible register at once
  task automatic snap(input logic [7:0] a, z, d5, d6, d7);
    check(accum, a);
    check({7'h00, zero}, z);
    check(dir5, d5);
    check(dir6, d6);
    check(dir7, d7);
  endtask : snap

  task automatic t_reset;
    snap(8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF);
    $display("test reset done");
  endtask : t_reset

  // literal xor chain ending on a zero result
  task automatic t_xlit;
    exec(14'h3AB5);
    snap(8'hB5, 8'h00, 8'hFF, 8'hFF, 8'hFF);
    exec(14'h3AAF);
    snap(8'h1A, 8'h00, 8'hFF, 8'hFF, 8'hFF);
    exec(14'h3A1A);
    snap(8'h00, 8'h01, 8'hFF, 8'hFF, 8'hFF);
    // out-of-range direction load with the zero flag set
    exec(14'h0062);
    snap(8'h00, 8'h01, 8'hFF, 8'hFF, 8'hFF);
    $display("test literal xor done");
  endtask : t_xlit

  // direction loads into all three targets, then out-of-range operands
  task automatic t_dir;
    exec(14'h3A3C);
    exec(14'h0065);
    snap(8'h3C, 8'h00, 8'h3C, 8'hFF, 8'hFF);
    exec(14'h3AFF);
    exec(14'h0066);
    snap(8'hC3, 8'h00, 8'h3C, 8'hC3, 8'hFF);
    exec(14'h3AC3);
    exec(14'h0067);
    snap(8'h00, 8'h01, 8'h3C, 8'hC3, 8'h00);
    exec(14'h3A5A);
    exec(14'h0064);
    exec(14'h0060);
    snap(8'h5A, 8'h00, 8'h3C, 8'hC3, 8'h00);
    $display("test direction load done");
  endtask : t_dir

  // file xor both ways, direction registers addressed as files
  task automatic t_xf;
    exec(14'h0685);
    snap(8'h5A, 8'h00, 8'h66, 8'hC3, 8'h00);
    exec(14'h0606);
    snap(8'h99, 8'h00, 8'h66, 8'hC3, 8'h00);
    exec(14'h0687);
    snap(8'h99, 8'h00, 8'h66, 8'hC3, 8'h99);
    exec(14'h0607);
    snap(8'h00, 8'h01, 8'h66, 8'hC3, 8'h99);
    $display("test file xor done");
  endtask : t_xf

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    instr = 14'h0000;
    repeat (10) @(posedge clk_sys);
    #10;
    t_reset();
    rstn = 1'b1;
    t_xlit();
    t_dir();
    t_xf();
    conclude();
  end
endmodule : xor_and_direction_load_ops_test

`default_nettype wire
